// >>> verilog/asw_pkg.sv
// Constants shared by the auto-sleep/wake controller and its step timer.
// Assumes a single 100 MHz clock and an 8-bit register port from the serial front end.
package asw_pkg;

	// ----------------------------------------
	// Timing
	// ----------------------------------------
	localparam int CLK_PERIOD_NS = 10;
	localparam int MS_NS = 1000000;
	localparam int MS_CYCLES_DEF = MS_NS / CLK_PERIOD_NS;
	localparam logic [10:0] STEP_MS_FAST = 11'h140;
	localparam logic [10:0] STEP_MS_SLOW = 11'h280;
	localparam logic [2:0] RATE_SLOWEST = 3'h7;

	// ----------------------------------------
	// Register offsets
	// ----------------------------------------
	localparam logic [7:0] OFS_SYSTEM_STATE = 8'h0B;
	localparam logic [7:0] OFS_INACT_COUNT = 8'h29;
	localparam logic [7:0] OFS_CONTROL_ONE = 8'h2A;
	localparam logic [7:0] OFS_CONTROL_TWO = 8'h2B;
	localparam logic [7:0] OFS_WAKE_CONTROL = 8'h2C;
	localparam logic [7:0] OFS_INT_ENABLE = 8'h2D;
	localparam logic [7:0] OFS_MAG_EVENT = 8'h5F;

	// ----------------------------------------
	// Reset values
	// ----------------------------------------
	localparam logic [7:0] RST_INACT_COUNT = 8'h00;
	localparam logic [7:0] RST_CONTROL_ONE = 8'h00;
	localparam logic [7:0] RST_CONTROL_TWO = 8'h00;
	localparam logic [7:0] RST_WAKE_CONTROL = 8'h00;
	localparam logic [7:0] RST_INT_ENABLE = 8'h00;
	localparam logic [7:0] RST_MAG_EVENT = 8'h00;

	// ----------------------------------------
	// Field positions
	// ----------------------------------------
	localparam int C1_ACTIVE = 0;
	localparam int C1_RATE_LO = 3;
	localparam int C1_SLEEP_RATE_LO = 6;
	localparam int C2_SLEEP_EN = 2;
	localparam int WC_FIFO_GATE = 7;
	localparam int WC_TRANS = 6;
	localparam int WC_ORIENT = 5;
	localparam int WC_TAP = 4;
	localparam int WC_FFMT = 3;
	localparam int WC_AVECM = 2;
	localparam int IE_SLEEP = 7;
	localparam int IE_FIFO = 6;
	localparam int IE_TRANS = 5;
	localparam int IE_ORIENT = 4;
	localparam int IE_TAP = 3;
	localparam int IE_FFMT = 2;
	localparam int IE_AVECM = 1;
	localparam int IE_DRDY = 0;
	localparam int ME_MAG_IE = 0;
	localparam int ME_MAG_WAKE = 1;
	localparam int ME_MVECM_IE = 2;
	localparam int ME_MVECM_WAKE = 3;
	localparam int ME_MTHS_IE = 4;
	localparam int ME_MTHS_WAKE = 5;
	localparam int ME_HYBRID = 6;
	localparam int SS_GATE_ERR = 7;

	// ----------------------------------------
	// System state encoding
	// ----------------------------------------
	typedef enum logic [1:0] {
		ASW_STANDBY = 2'b00,
		ASW_WAKE = 2'b01,
		ASW_SLEEP = 2'b10
	} asw_mode_t;

endpackage

// >>> verilog/asw_step_timer.sv
// Inactivity step timer: one pulse per step of step_ms milliseconds.
// Assumes restart is a level from the same clock domain.
module asw_step_timer
	import asw_pkg::*;
#(
	parameter int MS_CYCLES = MS_CYCLES_DEF
) (
	input wire logic clk,
	input wire logic rst_b,
	input wire logic restart,
	input wire logic [10:0] step_ms,
	output logic step_pulse
);

	logic [31:0] cyc_q, cyc_d;
	logic [10:0] ms_q, ms_d;
	logic step_d;

	always_comb begin
		cyc_d = cyc_q + 32'h1;
		ms_d = ms_q;
		step_d = 1'b0;
		if (restart) begin
			cyc_d = 32'h0;
			ms_d = 11'h0;
		end else if (cyc_q >= 32'(MS_CYCLES - 1)) begin
			cyc_d = 32'h0;
			if (ms_q + 11'h1 >= step_ms) begin
				ms_d = 11'h0;
				step_d = 1'b1;
			end else begin
				ms_d = ms_q + 11'h1;
			end
		end
	end

	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			cyc_q <= 32'h0;
			ms_q <= 11'h0;
			step_pulse <= 1'b0;
		end else begin
			cyc_q <= cyc_d;
			ms_q <= ms_d;
			step_pulse <= step_d;
		end
	end

endmodule

// >>> verilog/asw_sleep_ctrl.sv
// Auto-sleep/wake controller: inactivity counting, rate switching, sleep interrupt, FIFO gating.
// Assumes event flags, FIFO status and the register port all come from logic on clk.
// What this block does
// - 8-bit inactivity count, reset zero, sets idle time before sleep; needs sleep enable.
// - Step is 320 ms for 800..6.25 Hz, 640 ms at 1.56 Hz.
// - Hybrid mode halves effective rate, so the step length doubles.
// - Enabled return-to-sleep event before limit aborts sleep and clears the counter.
// - No qualifying event within the limit enters sleep at the sleep rate.
// - Enabled wake event with its wake bit set returns to the active rate.
// - Only sources with interrupt enabled take part in sleep and wake decisions.
// - Functions bypassed in sleep are off, re-enabled on wake, except data-ready.
// - Enabled sleep interrupt raised on each sleep/wake transition, cleared by reading 0x0B.
// - FIFO gating on sleep entry keeps contents, sets gate error, blocks FIFO until empty.
// - With gating, sleep interrupt never blocks transitions, only blocks FIFO until emptied.
// - Standby-to-wake and ungated sleep/wake changes flush the FIFO; rate writes alone do not.
// - Sleep interrupt enable bit, when 1, gates the sleep/wake interrupt.
module asw_sleep_ctrl
	import asw_pkg::*;
#(
	parameter int MS_CYCLES = MS_CYCLES_DEF
) (
	input wire logic clk,
	input wire logic rst_b,
	input wire logic reg_wr,
	input wire logic reg_rd,
	input wire logic [7:0] reg_addr,
	input wire logic [7:0] reg_wdata,
	output logic [7:0] reg_rdata,
	input wire logic evt_fifo,
	input wire logic evt_trans,
	input wire logic evt_orient,
	input wire logic evt_tap,
	input wire logic evt_ffmt,
	input wire logic evt_mag,
	input wire logic evt_avecm,
	input wire logic evt_mvecm,
	input wire logic evt_mths,
	input wire logic fifo_empty,
	output logic [2:0] sample_rate,
	output logic [1:0] sys_mode,
	output logic sleep_int,
	output logic fifo_flush,
	output logic fifo_block,
	output logic [9:0] func_enable
);

	// ----------------------------------------
	// State
	// ----------------------------------------
	asw_mode_t mode_q, mode_d;
	logic [7:0] count_q, count_d;
	logic [7:0] ctl1_q, ctl1_d;
	logic [7:0] ctl2_q, ctl2_d;
	logic [7:0] wake_q, wake_d;
	logic [7:0] ien_q, ien_d;
	logic [7:0] mag_q, mag_d;
	logic [7:0] inact_q, inact_d;
	logic int_d, gerr_q, gerr_d, flush_d, block_d, drdy_off_q, drdy_off_d;
	logic [2:0] rate_d;
	logic [7:0] rdata_d;
	logic [9:0] fen_d;
	logic rts_evt, wake_evt, restart, step, counting, rd_state;
	logic [10:0] step_ms;

	function automatic logic [10:0] step_len(input logic [2:0] rate, input logic hybrid);
		logic [10:0] base;
		base = (rate == RATE_SLOWEST) ? STEP_MS_SLOW : STEP_MS_FAST;
		step_len = hybrid ? 11'(base << 1) : base;
	endfunction

	// ----------------------------------------
	// Event qualification
	// ----------------------------------------
	assign rts_evt = (evt_fifo & ien_q[IE_FIFO]) | (evt_trans & ien_q[IE_TRANS])
		| (evt_orient & ien_q[IE_ORIENT]) | (evt_tap & ien_q[IE_TAP]) | (evt_ffmt & ien_q[IE_FFMT])
		| (evt_avecm & ien_q[IE_AVECM]) | (evt_mag & mag_q[ME_MAG_IE])
		| (evt_mvecm & mag_q[ME_MVECM_IE]) | (evt_mths & mag_q[ME_MTHS_IE]);
	assign wake_evt = (evt_trans & ien_q[IE_TRANS] & wake_q[WC_TRANS])
		| (evt_orient & ien_q[IE_ORIENT] & wake_q[WC_ORIENT])
		| (evt_tap & ien_q[IE_TAP] & wake_q[WC_TAP])
		| (evt_ffmt & ien_q[IE_FFMT] & wake_q[WC_FFMT])
		| (evt_avecm & ien_q[IE_AVECM] & wake_q[WC_AVECM])
		| (evt_mag & mag_q[ME_MAG_IE] & mag_q[ME_MAG_WAKE])
		| (evt_mvecm & mag_q[ME_MVECM_IE] & mag_q[ME_MVECM_WAKE])
		| (evt_mths & mag_q[ME_MTHS_IE] & mag_q[ME_MTHS_WAKE]);
	assign counting = (mode_q == ASW_WAKE) && ctl2_q[C2_SLEEP_EN];
	assign restart = !counting || rts_evt;
	assign step_ms = step_len(ctl1_q[C1_RATE_LO +: 3], mag_q[ME_HYBRID]);
	assign rd_state = reg_rd && (reg_addr == OFS_SYSTEM_STATE);

	asw_step_timer #(
		.MS_CYCLES(MS_CYCLES)
	) u_timer (
		.clk(clk),
		.rst_b(rst_b),
		.restart(restart),
		.step_ms(step_ms),
		.step_pulse(step)
	);

	// ----------------------------------------
	// Next-state logic
	// ----------------------------------------
	always_comb begin
		mode_d = mode_q;
		count_d = count_q;
		ctl1_d = ctl1_q;
		ctl2_d = ctl2_q;
		wake_d = wake_q;
		ien_d = ien_q;
		mag_d = mag_q;
		inact_d = inact_q;
		int_d = sleep_int;
		gerr_d = gerr_q;
		block_d = fifo_block;
		drdy_off_d = drdy_off_q;
		flush_d = 1'b0;
		rdata_d = reg_rdata;

		// Register writes
		if (reg_wr) begin
			if (reg_addr == OFS_INACT_COUNT) begin
				count_d = reg_wdata;
			end else if (reg_addr == OFS_CONTROL_ONE) begin
				ctl1_d = reg_wdata;
			end else if (reg_addr == OFS_CONTROL_TWO) begin
				ctl2_d = reg_wdata;
			end else if (reg_addr == OFS_WAKE_CONTROL) begin
				wake_d = reg_wdata;
			end else if (reg_addr == OFS_INT_ENABLE) begin
				ien_d = reg_wdata;
				drdy_off_d = 1'b0;
			end else if (reg_addr == OFS_MAG_EVENT) begin
				mag_d = reg_wdata;
			end
		end

		// Register reads
		if (reg_rd) begin
			if (reg_addr == OFS_SYSTEM_STATE) begin
				rdata_d = {gerr_q, 5'h00, mode_q};
			end else if (reg_addr == OFS_INACT_COUNT) begin
				rdata_d = count_q;
			end else if (reg_addr == OFS_CONTROL_ONE) begin
				rdata_d = ctl1_q;
			end else if (reg_addr == OFS_CONTROL_TWO) begin
				rdata_d = ctl2_q;
			end else if (reg_addr == OFS_WAKE_CONTROL) begin
				rdata_d = wake_q;
			end else if (reg_addr == OFS_INT_ENABLE) begin
				rdata_d = ien_q;
			end else if (reg_addr == OFS_MAG_EVENT) begin
				rdata_d = mag_q;
			end else begin
				rdata_d = 8'h00;
			end
			if (rd_state) begin
				int_d = 1'b0;
			end
		end

		// Inactivity counting
		if (restart) begin
			inact_d = 8'h00;
		end else if (step && inact_q != 8'hFF) begin
			inact_d = inact_q + 8'h01;
		end

		// Mode sequencing
		case (mode_q)
			ASW_STANDBY: begin
				if (ctl1_q[C1_ACTIVE]) begin
					mode_d = ASW_WAKE;
					flush_d = 1'b1;
				end
			end
			ASW_WAKE: begin
				if (!ctl1_q[C1_ACTIVE]) begin
					mode_d = ASW_STANDBY;
				end else if (counting && !rts_evt && inact_q >= count_q) begin
					mode_d = ASW_SLEEP;
					drdy_off_d = 1'b1;
					if (ien_q[IE_SLEEP]) begin
						int_d = 1'b1;
					end
					if (wake_q[WC_FIFO_GATE]) begin
						gerr_d = 1'b1;
						block_d = 1'b1;
					end else begin
						flush_d = 1'b1;
					end
				end
			end
			ASW_SLEEP: begin
				if (!ctl1_q[C1_ACTIVE]) begin
					mode_d = ASW_STANDBY;
				end else if (wake_evt || !ctl2_q[C2_SLEEP_EN]) begin
					mode_d = ASW_WAKE;
					if (ien_q[IE_SLEEP]) begin
						int_d = 1'b1;
					end
					if (wake_q[WC_FIFO_GATE]) begin
						block_d = 1'b1;
					end else begin
						flush_d = 1'b1;
					end
				end
			end
			default: begin
				mode_d = ASW_STANDBY;
			end
		endcase

		// FIFO gate released once the host has drained the buffer
		if (fifo_block && fifo_empty && !block_d) begin
			block_d = 1'b0;
		end else if (fifo_block && fifo_empty && mode_d == mode_q) begin
			block_d = 1'b0;
			gerr_d = 1'b0;
		end

		// Output rate and function enables
		rate_d = (mode_d == ASW_SLEEP) ? {1'b1, ctl1_q[C1_SLEEP_RATE_LO +: 2]} : ctl1_q[C1_RATE_LO +: 3];
		if (mode_d == ASW_SLEEP) begin
			fen_d = {mag_q[ME_MTHS_IE] & mag_q[ME_MTHS_WAKE], mag_q[ME_MVECM_IE] & mag_q[ME_MVECM_WAKE],
				mag_q[ME_MAG_IE] & mag_q[ME_MAG_WAKE], 1'b0, ien_d[IE_TRANS:IE_AVECM] & wake_q[WC_TRANS:WC_AVECM],
				1'b0};
		end else begin
			fen_d = {mag_q[ME_MTHS_IE], mag_q[ME_MVECM_IE], mag_q[ME_MAG_IE], ien_d[IE_FIFO:IE_AVECM],
				ien_d[IE_DRDY] & !drdy_off_d};
		end
	end

	// ----------------------------------------
	// Registers
	// ----------------------------------------
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			mode_q <= ASW_STANDBY;
			count_q <= RST_INACT_COUNT;
			ctl1_q <= RST_CONTROL_ONE;
			ctl2_q <= RST_CONTROL_TWO;
			wake_q <= RST_WAKE_CONTROL;
			ien_q <= RST_INT_ENABLE;
			mag_q <= RST_MAG_EVENT;
			inact_q <= 8'h00;
			sleep_int <= 1'b0;
			gerr_q <= 1'b0;
			fifo_block <= 1'b0;
			drdy_off_q <= 1'b0;
			fifo_flush <= 1'b0;
			sample_rate <= 3'h0;
			sys_mode <= 2'h0;
			func_enable <= 10'h000;
			reg_rdata <= 8'h00;
		end else begin
			mode_q <= mode_d;
			count_q <= count_d;
			ctl1_q <= ctl1_d;
			ctl2_q <= ctl2_d;
			wake_q <= wake_d;
			ien_q <= ien_d;
			mag_q <= mag_d;
			inact_q <= inact_d;
			sleep_int <= int_d;
			gerr_q <= gerr_d;
			fifo_block <= block_d;
			drdy_off_q <= drdy_off_d;
			fifo_flush <= flush_d;
			sample_rate <= rate_d;
			sys_mode <= mode_d;
			func_enable <= fen_d;
			reg_rdata <= rdata_d;
		end
	end

endmodule

// >>> testbench/asw_sleep_ctrl_asserts.sv
// Port-level checker for the auto-sleep/wake controller.
// Assumes it is bound to asw_sleep_ctrl with ports connected by name.
module asw_sleep_ctrl_asserts
	import asw_pkg::*;
(
	input wire logic clk,
	input wire logic rst_b,
	input wire logic reg_rd,
	input wire logic [7:0] reg_addr,
	input wire logic [7:0] reg_rdata,
	input wire logic fifo_empty,
	input wire logic [2:0] sample_rate,
	input wire logic [1:0] sys_mode,
	input wire logic sleep_int,
	input wire logic fifo_flush,
	input wire logic fifo_block,
	input wire logic [9:0] func_enable
);
	timeunit 1ns;
	timeprecision 1ps;
	default clocking cb @(posedge clk); endclocking
	default disable iff (!rst_b);
	// ----
	// Properties
	// ----
	sequence s_rd_state;
		reg_rd && reg_addr == OFS_SYSTEM_STATE;
	endsequence
	property p_rd_state;
		s_rd_state |=> reg_rdata[1:0] == $past(sys_mode) && reg_rdata[6:2] == 5'h00;
	endproperty
	// A wake with gating also blocks the FIFO but leaves the gate error alone
	property p_gerr;
		s_rd_state ##0 fifo_block && sys_mode == ASW_SLEEP |=> reg_rdata[7];
	endproperty
	property p_int_clr;
		s_rd_state ##1 $stable(sys_mode) |-> !sleep_int;
	endproperty
	property p_int_set;
		$rose(sleep_int) |-> $changed(sys_mode);
	endproperty
	property p_rate_flush;
		$changed(sample_rate) |-> fifo_flush || fifo_block;
	endproperty
	property p_sleep_rate;
		sys_mode == ASW_SLEEP |-> sample_rate[2] == 1'b1;
	endproperty
	property p_block_hold;
		fifo_block && !fifo_empty |=> fifo_block;
	endproperty
	property p_sleep_funcs;
		sys_mode == ASW_SLEEP |-> func_enable[0] == 1'b0 && func_enable[6] == 1'b0;
	endproperty
	a_rd_state: assert property (p_rd_state) else $error("state read wrong");
	a_gerr: assert property (p_gerr) else $error("gate error bit missing");
	a_int_clr: assert property (p_int_clr) else $error("irq not cleared");
	a_int_set: assert property (p_int_set) else $error("irq without transition");
	a_rate_flush: assert property (p_rate_flush) else $error("rate change without flush");
	a_sleep_rate: assert property (p_sleep_rate) else $error("sleep rate wrong");
	a_block_hold: assert property (p_block_hold) else $error("block released early");
	a_sleep_funcs: assert property (p_sleep_funcs) else $error("function left on");
endmodule

// >>> testbench/asw_host_model.sv
// Host side of the register port: single-byte writes and reads.
// Assumes strobes are sampled on the rising clock edge.
module asw_host_model (
	input wire logic clk,
	input wire logic [7:0] reg_rdata,
	output logic reg_wr,
	output logic reg_rd,
	output logic [7:0] reg_addr,
	output logic [7:0] reg_wdata
);
	timeunit 1ns;
	timeprecision 1ps;
	initial begin
		reg_wr = 1'b0;
		reg_rd = 1'b0;
		reg_addr = 8'hFF;
		reg_wdata = 8'hFF;
	end
	// Idle address and data show the inverse of the last value
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge clk);
		reg_wr <= 1'b1;
		reg_addr <= a;
		reg_wdata <= d;
		@(posedge clk);
		reg_wr <= 1'b0;
		reg_addr <= ~a;
		reg_wdata <= ~d;
	endtask
	task automatic rd(input logic [7:0] a, output logic [7:0] d);
		@(posedge clk);
		reg_rd <= 1'b1;
		reg_addr <= a;
		@(posedge clk);
		reg_rd <= 1'b0;
		reg_addr <= ~a;
		#1 d = reg_rdata;
	endtask
endmodule

// >>> testbench/asw_sleep_ctrl_tb.sv
// Self-checking bench for the auto-sleep/wake controller.
// Assumes MS_CYCLES of 10, so one 320 ms step is 3200 clocks.
`define CHK(n, e, s) begin cmp_count++; if ((s) !== (e)) begin failures++; \
	$display("CHECK FAILED %s exp %0h got %0h", n, e, s); end end
module asw_sleep_ctrl_tb
	import asw_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ps;
	typedef struct {logic [7:0] ie, wc, me; int idx; logic wake, irq;} asw_row_t;
	logic clk = 1'b0, rst_b = 1'b0, fifo_empty = 1'b1;
	logic [8:0] ev = 9'h000;
	logic reg_wr, reg_rd, sleep_int, fifo_flush, fifo_block;
	logic [7:0] reg_addr, reg_wdata, reg_rdata, rv;
	logic [2:0] sample_rate;
	logic [1:0] sys_mode;
	logic [9:0] func_enable;
	int failures = 0, cmp_count = 0;
	asw_row_t rows [11] = '{'{8'hE1, 8'h40, 8'h00, 1, 1, 1}, '{8'hD0, 8'h20, 8'h00, 2, 1, 1},
		'{8'hC8, 8'h10, 8'h00, 3, 1, 1}, '{8'hC4, 8'h08, 8'h00, 4, 1, 1}, '{8'hC2, 8'h04, 8'h00, 6, 1, 1},
		'{8'hC0, 8'h00, 8'h03, 5, 1, 1}, '{8'hC0, 8'h00, 8'h0C, 7, 1, 1}, '{8'hC0, 8'h00, 8'h30, 8, 1, 1},
		'{8'h48, 8'h10, 8'h00, 0, 0, 0}, '{8'hC0, 8'h10, 8'h00, 3, 0, 1}, '{8'h48, 8'h00, 8'h00, 3, 0, 0}};
	always #5 clk = ~clk;
	asw_host_model hm (.clk(clk), .reg_rdata(reg_rdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
		.reg_addr(reg_addr), .reg_wdata(reg_wdata));
	asw_sleep_ctrl #(.MS_CYCLES(10)) uut (.clk(clk), .rst_b(rst_b), .reg_wr(reg_wr), .reg_rd(reg_rd),
		.reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .evt_fifo(ev[0]),
		.evt_trans(ev[1]), .evt_orient(ev[2]), .evt_tap(ev[3]), .evt_ffmt(ev[4]), .evt_mag(ev[5]),
		.evt_avecm(ev[6]), .evt_mvecm(ev[7]), .evt_mths(ev[8]), .fifo_empty(fifo_empty),
		.sample_rate(sample_rate), .sys_mode(sys_mode), .sleep_int(sleep_int), .fifo_flush(fifo_flush),
		.fifo_block(fifo_block), .func_enable(func_enable));
	// ----
	// Tasks
	// ----
	task automatic give_verdict();
		$display("comparisons %0d mismatches %0d", cmp_count, failures);
		if (failures == 0 && cmp_count > 0) begin
			$display("SIMULATION PASSED");
		end else begin
			$display("SIMULATION FAILED");
		end
		$finish;
	endtask
	task automatic cyc(input int n);
		repeat (n) @(posedge clk);
	endtask
	task automatic pulse(input int i);
		@(posedge clk);
		ev[i] <= 1'b1;
		@(posedge clk);
		ev[i] <= 1'b0;
		cyc(2);
	endtask
	// Wake by clearing sleep enable, restart the idle time, then wait for sleep
	task automatic to_sleep(input int n, input logic g);
		int k;
		hm.wr(OFS_CONTROL_TWO, 8'h00);
		hm.wr(OFS_CONTROL_TWO, 8'h04);
		pulse(0);
		hm.rd(OFS_SYSTEM_STATE, rv);
		cyc(n - 70);
		`CHK("early mode", 2'b01, sys_mode)
		k = 0;
		while (sys_mode !== 2'b10 && k < 140) begin
			@(posedge clk);
			k++;
		end
		if (k == 140) begin
			failures++;
			give_verdict();
		end
		`CHK("sleep rate", 3'h5, sample_rate)
		`CHK("sleep flush", !g, fifo_flush)
	endtask
	// ----
	// Sequence
	// ----
	initial begin
		cyc(4);
		rst_b <= 1'b1;
		hm.rd(OFS_INACT_COUNT, rv);
		`CHK("count reset", 8'h00, rv)
		hm.wr(8'h30, 8'h55);
		hm.rd(8'h30, rv);
		`CHK("unmapped", 8'h00, rv)
		hm.wr(OFS_INACT_COUNT, 8'h01);
		hm.wr(OFS_CONTROL_ONE, 8'h51);
		for (int r = 0; r < 11; r++) begin
			hm.wr(OFS_INT_ENABLE, rows[r].ie);
			hm.wr(OFS_WAKE_CONTROL, rows[r].wc);
			hm.wr(OFS_MAG_EVENT, rows[r].me);
			if (r == 0) `CHK("drdy on", 1'b1, func_enable[0])
			to_sleep(3200, 1'b0);
			`CHK("sleep irq", rows[r].irq, sleep_int)
			`CHK("drdy off", 1'b0, func_enable[0])
			hm.rd(OFS_SYSTEM_STATE, rv);
			`CHK("state", 8'h02, rv)
			`CHK("irq clear", 1'b0, sleep_int)
			pulse(rows[r].idx);
			`CHK("mode", rows[r].wake ? 2'b01 : 2'b10, sys_mode)
			if (rows[r].wake) `CHK("active rate", 3'h2, sample_rate)
			if (rows[r].wake) `CHK("drdy stays off", 1'b0, func_enable[0])
			$display("row %0d done", r);
		end
		hm.wr(OFS_INT_ENABLE, 8'hC0);
		hm.wr(OFS_WAKE_CONTROL, 8'h00);
		hm.wr(OFS_CONTROL_ONE, 8'h79);
		to_sleep(6400, 1'b0);
		$display("slow step done");
		hm.wr(OFS_CONTROL_ONE, 8'h51);
		hm.wr(OFS_MAG_EVENT, 8'h40);
		to_sleep(6400, 1'b0);
		$display("hybrid done");
		hm.wr(OFS_MAG_EVENT, 8'h00);
		hm.wr(OFS_WAKE_CONTROL, 8'h80);
		fifo_empty <= 1'b0;
		to_sleep(3200, 1'b1);
		`CHK("fifo block", 1'b1, fifo_block)
		hm.rd(OFS_SYSTEM_STATE, rv);
		`CHK("gate error", 8'h82, rv)
		fifo_empty <= 1'b1;
		cyc(3);
		`CHK("block release", 1'b0, fifo_block)
		$display("gate done");
		rst_b <= 1'b0;
		cyc(2);
		rst_b <= 1'b1;
		hm.rd(OFS_INACT_COUNT, rv);
		`CHK("count after reset", 8'h00, rv)
		$display("reset done");
		give_verdict();
	end
endmodule
bind asw_sleep_ctrl asw_sleep_ctrl_asserts u_chk (.clk, .rst_b, .reg_rd, .reg_addr, .reg_rdata, .fifo_empty,
	.sample_rate, .sys_mode, .sleep_int, .fifo_flush, .fifo_block, .func_enable);
